// ===== design/smc_pkg.sv
// shared constants, clock and wake-source types for the sleep mode controller
package smc_pkg;

  // ==========================================================
  // sleep depth encodings
  localparam logic [1:0] MODE_IDLE   = 2'h0;
  localparam logic [1:0] MODE_ADC_NR = 2'h1;
  localparam logic [1:0] MODE_PDOWN  = 2'h2;
  localparam logic [1:0] MODE_PSAVE  = 2'h3;

  // ==========================================================
  // timing
  localparam int CLK_MHZ         = 125;
  localparam int HALT_CYCLES     = 4;
  localparam int BOD_WAKE_US     = 60;
  localparam int BOD_WAKE_CYCLES = BOD_WAKE_US * CLK_MHZ;
  localparam int CNT_W           = 16;

  // brown-out sleep-off timed sequence
  localparam logic [2:0] BROWNOUT_SLEEP_OFF_UNLOCK_WINDOW = 3'h4;
  localparam logic [2:0] BROWNOUT_SLEEP_OFF_EFFECT_DELAY  = 3'h3;
  localparam logic [2:0] BROWNOUT_SLEEP_OFF_LIFE          = 3'h6;

  // start-up counts picked by clock_source_fuses[3:2]
  localparam logic [15:0] STARTUP_CNT_0 = 16'h0040;
  localparam logic [15:0] STARTUP_CNT_1 = 16'h0100;
  localparam logic [15:0] STARTUP_CNT_2 = 16'h0400;
  localparam logic [15:0] STARTUP_CNT_3 = 16'h1000;

  // ==========================================================
  // clock domain enables
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic main_osc;
    logic t0_osc;
  } smc_clk_s;

  localparam smc_clk_s CLK_ALL_ON = 7'h7f;
  localparam smc_clk_s CLK_IDLE   = 7'h1f;
  localparam smc_clk_s CLK_ADC_NR = 7'h0f;
  localparam smc_clk_s CLK_PDOWN  = 7'h00;
  localparam smc_clk_s CLK_PSAVE  = 7'h05;
  localparam smc_clk_s CLK_OSC_ON = 7'h02; // main oscillator bit only

  // wake requests, already qualified by their own enables except timer zero
  typedef struct packed {
    logic ext_a;
    logic ext_a_level;
    logic ext_b;
    logic ext_b_level;
    logic pin_change;
    logic spi;
    logic other_io;
    logic wdt_irq;
    logic t0_ovf;
    logic t0_cmp;
    logic adc_done;
    logic usi_start;
    logic spm_ready;
    logic sys_reset;
  } smc_wake_s;

  // ==========================================================
  // clock enables for a sleep depth
  function automatic smc_clk_s smc_mode_clocks(input logic [1:0] mode);
    case (mode)
      MODE_IDLE:   smc_mode_clocks = CLK_IDLE;
      MODE_ADC_NR: smc_mode_clocks = CLK_ADC_NR;
      MODE_PDOWN:  smc_mode_clocks = CLK_PDOWN;
      default:     smc_mode_clocks = CLK_PSAVE;
    endcase
  endfunction

  // oscillator restart time from the clock source fuses
  function automatic logic [15:0] smc_startup_cycles(input logic [3:0] fuses);
    case (fuses[3:2])
      2'h0:    smc_startup_cycles = STARTUP_CNT_0;
      2'h1:    smc_startup_cycles = STARTUP_CNT_1;
      2'h2:    smc_startup_cycles = STARTUP_CNT_2;
      default: smc_startup_cycles = STARTUP_CNT_3;
    endcase
  endfunction

  // deep modes stop the main oscillator
  function automatic logic smc_is_deep(input logic [1:0] mode);
    smc_is_deep = mode[1];
  endfunction

endpackage

// ===== design/smc_bod_seq.sv
// timed write sequence and lifetime of the brown-out sleep-off bit
`timescale 1ns/1ns
module smc_bod_seq
  import smc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic wr,
  input  wire logic wr_off,
  input  wire logic wr_unlock,
  output logic      off_flag,
  output logic      off_effective
);

  logic [2:0] unlock_cnt;
  logic [2:0] age;
  logic [2:0] next_unlock_cnt;
  logic [2:0] next_age;

  // ==========================================================
  // unlock window and age of the set bit
  always_comb begin
    next_unlock_cnt = (unlock_cnt != 3'h0) ? unlock_cnt - 3'h1 : 3'h0;
    next_age        = (age != 3'h0 && age != BROWNOUT_SLEEP_OFF_LIFE) ? age + 3'h1 : 3'h0;
    if (wr && wr_off && wr_unlock) begin
      next_unlock_cnt = BROWNOUT_SLEEP_OFF_UNLOCK_WINDOW;
    end else if (wr && wr_off && !wr_unlock && unlock_cnt != 3'h0 && age == 3'h0) begin
      next_age        = 3'h1;
      next_unlock_cnt = 3'h0;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unlock_cnt <= 3'h0;
      age        <= 3'h0;
    end else begin
      unlock_cnt <= next_unlock_cnt;
      age        <= next_age;
    end
  end

  assign off_flag      = (age != 3'h0);
  assign off_effective = (age > BROWNOUT_SLEEP_OFF_EFFECT_DELAY);

  // ==========================================================
  // checks
  sequence s_flag_life;
    off_flag [*6] ##1 !off_flag;
  endsequence

  sequence s_effect_after_three;
    !off_effective [*3] ##1 off_effective [*3] ##1 !off_effective;
  endsequence

  AST_BROWNOUT_SLEEP_OFF_LIFE: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(off_flag) |-> s_flag_life)
    else $error("sleep-off bit lifetime wrong");

  AST_BROWNOUT_SLEEP_OFF_EFFECT: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(off_flag) |-> s_effect_after_three)
    else $error("sleep-off bit effective window wrong");

endmodule

// ===== design/smc_sleep_ctrl.sv
// sleep mode controller: clock gating, wake selection and wake-up sequencing
`timescale 1ns/1ns

// How it works
// - Depth 00 Idle stops cpu and flash clocks; others and oscillator run.
// - In Idle any enabled interrupt wakes the device.
// - Depth 01 noise reduction stops io, cpu and flash clocks only.
// - Entering Idle or noise reduction with converter enabled starts a conversion.
// - Noise reduction wakes only on converter, resets, watchdog, serial, timer, ready, level, pin.
// - Depth 10 power-down stops oscillator and every generated clock.
// - Power-down wakes only on resets, watchdog, serial start, level lines, pin change.
// - Outside Idle the external lines wake only as level interrupts.
// - Leaving power-down waits a start-up time chosen by the clock source fuses.
// - Depth 11 power-save is power-down with async clock and timer oscillator kept.
// - Power-save timer events wake only with async timer, mask bit and global enable.
// - Interrupt wake halts the core four cycles after start-up, then resumes.
// - Register and memory contents survive sleep; reset during sleep restarts at reset.
// - Sleep-off bit turns detector off in deep modes and back on at wake.
// - Wake after detector was off is stretched by about 60 us after start-up.
// - Sleep-off bit takes effect after three cycles and clears three cycles later.
module smc_sleep_ctrl
  import smc_pkg::*;
#(
  parameter int BOD_WAKE_CYCLES_P = BOD_WAKE_CYCLES
)(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       sleep_instr,
  input  wire logic       sleep_arm,
  input  wire logic [1:0] sleep_depth_select,
  input  wire logic [3:0] clock_source_fuses,
  input  wire logic       adc_enabled,
  input  wire logic       timer0_async_select,
  input  wire logic [1:0] timer0_irq_mask,
  input  wire logic       global_irq_enable,
  input  wire smc_wake_s  wake,
  input  wire logic       ctrl_wr,
  input  wire logic       wr_brownout_sleep_off,
  input  wire logic       wr_brownout_sleep_unlock,
  output smc_clk_s        clk_en,
  output logic            adc_start,
  output logic            brownout_enable,
  output logic            brownout_sleep_off,
  output logic            core_halt,
  output logic            sleeping,
  output logic            resume_irq,
  output logic            resume_reset
);

  typedef enum logic [4:0] {
    ST_RUN     = 5'h01,
    ST_SLEEP   = 5'h02,
    ST_STARTUP = 5'h04,
    ST_BODWAIT = 5'h08,
    ST_HALT    = 5'h10
  } smc_state_e;

  smc_state_e       state;
  smc_state_e       next_state;
  logic [1:0]       mode;
  logic [1:0]       next_mode;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             bod_was_off;
  logic             next_bod_was_off;
  logic             by_reset;
  logic             next_by_reset;
  smc_clk_s         next_clk_en;
  logic             next_adc_start;
  logic             next_brownout_enable;
  logic             next_core_halt;
  logic             next_resume_irq;
  logic             next_resume_reset;
  logic             brownout_sleep_off_flag;
  logic             brownout_sleep_off_eff;
  logic             wake_hit;

  // ==========================================================
  // sleep-off timed sequence
  smc_bod_seq i_smc_bod_seq (
    .clk           (clk),
    .rst_b         (rst_b),
    .wr            (ctrl_wr),
    .wr_off        (wr_brownout_sleep_off),
    .wr_unlock     (wr_brownout_sleep_unlock),
    .off_flag      (brownout_sleep_off_flag),
    .off_effective (brownout_sleep_off_eff)
  );

  // ==========================================================
  // wake source filter per sleep depth
  function automatic logic smc_wake_hit(input logic [1:0] m, input smc_wake_s w,
                                        input logic t0_ok);
    logic lvl;
    logic t0;
    lvl = (w.ext_a && w.ext_a_level) || (w.ext_b && w.ext_b_level);
    t0  = t0_ok && w.t0_ovf && timer0_irq_mask[0] || t0_ok && w.t0_cmp && timer0_irq_mask[1];
    case (m)
      MODE_IDLE: smc_wake_hit = w.ext_a || w.ext_b || w.pin_change || w.spi || w.other_io
                             || w.wdt_irq || t0 || w.adc_done || w.usi_start
                             || w.spm_ready || w.sys_reset;
      MODE_ADC_NR: smc_wake_hit = w.adc_done || w.sys_reset || w.wdt_irq || w.usi_start
                               || t0 || w.spm_ready || lvl || w.pin_change;
      MODE_PDOWN: smc_wake_hit = w.sys_reset || w.wdt_irq || w.usi_start
                              || lvl || w.pin_change;
      default: smc_wake_hit = w.sys_reset || w.wdt_irq || w.usi_start || lvl
                           || w.pin_change || (timer0_async_select && t0);
    endcase
  endfunction

  assign wake_hit = smc_wake_hit(mode, wake, global_irq_enable);

  // ==========================================================
  // next state of the sequencer
  always_comb begin
    next_state           = state;
    next_mode            = mode;
    next_cnt             = cnt;
    next_bod_was_off     = bod_was_off;
    next_by_reset        = by_reset;
    next_clk_en          = clk_en;
    next_adc_start       = 1'b0;
    next_brownout_enable = brownout_enable;
    next_resume_irq      = 1'b0;
    next_resume_reset    = 1'b0;
    case (state)
      ST_RUN: begin
        // unarmed sleep instruction falls through as a no-op
        if (sleep_instr && sleep_arm) begin
          next_state       = ST_SLEEP;
          next_mode        = sleep_depth_select;
          next_clk_en      = smc_mode_clocks(sleep_depth_select);
          next_adc_start   = adc_enabled && !smc_is_deep(sleep_depth_select);
          next_bod_was_off = brownout_sleep_off_eff && smc_is_deep(sleep_depth_select);
          next_brownout_enable = !(brownout_sleep_off_eff && smc_is_deep(sleep_depth_select));
        end
      end
      ST_SLEEP: begin
        // clocks are gated, never reset, so core state is retained
        if (wake_hit) begin
          next_state           = ST_STARTUP;
          next_by_reset        = wake.sys_reset;
          next_brownout_enable = 1'b1;
          next_clk_en          = smc_mode_clocks(mode) | CLK_OSC_ON;
          next_cnt             = smc_is_deep(mode) ? smc_startup_cycles(clock_source_fuses)
                                                   : '0;
        end
      end
      ST_STARTUP: begin
        if (cnt != '0) begin
          next_cnt = cnt - 16'h0001;
        end else if (bod_was_off) begin
          next_state = ST_BODWAIT;
          next_cnt   = CNT_W'(BOD_WAKE_CYCLES_P - 1);
        end else begin
          next_state  = ST_HALT;
          next_clk_en = CLK_ALL_ON;
          next_cnt    = CNT_W'(HALT_CYCLES - 1);
        end
      end
      ST_BODWAIT: begin
        if (cnt != '0) begin
          next_cnt = cnt - 16'h0001;
        end else begin
          next_state  = ST_HALT;
          next_clk_en = CLK_ALL_ON;
          next_cnt    = CNT_W'(HALT_CYCLES - 1);
        end
      end
      ST_HALT: begin
        if (cnt != '0) begin
          next_cnt = cnt - 16'h0001;
        end else begin
          next_state        = ST_RUN;
          next_bod_was_off  = 1'b0;
          next_resume_irq   = !by_reset;
          next_resume_reset = by_reset;
        end
      end
      default: begin
        next_state  = ST_RUN;
        next_clk_en = CLK_ALL_ON;
      end
    endcase
    next_core_halt = (next_state == ST_HALT);
  end

  // state registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state              <= ST_RUN;
      mode               <= MODE_IDLE;
      cnt                <= '0;
      bod_was_off        <= 1'b0;
      by_reset           <= 1'b0;
      clk_en             <= CLK_ALL_ON;
      adc_start          <= 1'b0;
      brownout_enable    <= 1'b1;
      brownout_sleep_off <= 1'b0;
      core_halt          <= 1'b0;
      sleeping           <= 1'b0;
      resume_irq         <= 1'b0;
      resume_reset       <= 1'b0;
    end else begin
      state              <= next_state;
      mode               <= next_mode;
      cnt                <= next_cnt;
      bod_was_off        <= next_bod_was_off;
      by_reset           <= next_by_reset;
      clk_en             <= next_clk_en;
      adc_start          <= next_adc_start;
      brownout_enable    <= next_brownout_enable;
      brownout_sleep_off <= brownout_sleep_off_flag;
      core_halt          <= next_core_halt;
      sleeping           <= (next_state != ST_RUN);
      resume_irq         <= next_resume_irq;
      resume_reset       <= next_resume_reset;
    end
  end

  // ==========================================================
  // checks
  sequence s_enter(logic [1:0] m);
    state == ST_RUN && sleep_instr && sleep_arm && sleep_depth_select == m;
  endsequence

  AST_UNARMED_NOP: assert property (@(posedge clk) disable iff (!rst_b)
    state == ST_RUN && clk_en == CLK_ALL_ON && sleep_instr && !sleep_arm
    |=> state == ST_RUN && clk_en == CLK_ALL_ON)
    else $error("unarmed sleep changed clocks");

  AST_IDLE_CLOCKS: assert property (@(posedge clk) disable iff (!rst_b)
    s_enter(MODE_IDLE) |=> clk_en == CLK_IDLE && sleeping)
    else $error("idle clock set wrong");

  AST_ADCNR_CLOCKS: assert property (@(posedge clk) disable iff (!rst_b)
    s_enter(MODE_ADC_NR) |=> clk_en == CLK_ADC_NR)
    else $error("noise reduction clock set wrong");

  AST_PDOWN_CLOCKS: assert property (@(posedge clk) disable iff (!rst_b)
    state == ST_SLEEP && mode == MODE_PDOWN |-> clk_en == CLK_PDOWN)
    else $error("power-down left a clock running");

  AST_PSAVE_CLOCKS: assert property (@(posedge clk) disable iff (!rst_b)
    state == ST_SLEEP && mode == MODE_PSAVE |-> clk_en == CLK_PSAVE)
    else $error("power-save clock set wrong");

  AST_ADC_START: assert property (@(posedge clk) disable iff (!rst_b)
    state == ST_RUN && sleep_instr && sleep_arm && !sleep_depth_select[1] && adc_enabled
    |=> adc_start ##1 !adc_start)
    else $error("no conversion at entry");

  AST_NO_WAKE_STAYS: assert property (@(posedge clk) disable iff (!rst_b)
    state == ST_SLEEP && !wake_hit |=> state == ST_SLEEP)
    else $error("left sleep without a wake source");

  AST_WAKE_TAKEN: assert property (@(posedge clk) disable iff (!rst_b)
    state == ST_SLEEP && wake_hit |=> state == ST_STARTUP && brownout_enable && clk_en.main_osc)
    else $error("wake source ignored");

  AST_HALT_FOUR: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(core_halt) |-> core_halt [*4] ##1 (!core_halt && (resume_irq || resume_reset)))
    else $error("core halt length wrong");

  AST_BOD_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    state == ST_SLEEP && bod_was_off |-> !brownout_enable)
    else $error("detector on during sleep-off");

endmodule

// ===== verif/smc_core_model.sv
// processor core model: sleep instruction and core control register writes
`timescale 1ns/1ns
module smc_core_model
  import smc_pkg::*;
(
  input  wire logic  clk,
  output logic       sleep_instr,
  output logic       sleep_arm,
  output logic [1:0] sleep_depth_select,
  output logic       ctrl_wr,
  output logic       wr_brownout_sleep_off,
  output logic       wr_brownout_sleep_unlock
);
  // ==========================================================
  // idle core: nothing requested until a task is called
  initial begin
    sleep_instr              = 1'b0;
    sleep_arm                = 1'b0;
    sleep_depth_select       = 2'h0;
    ctrl_wr                  = 1'b0;
    wr_brownout_sleep_off    = 1'b0;
    wr_brownout_sleep_unlock = 1'b0;
  end

  // ==========================================================
  // arm first, then a one-cycle sleep instruction; the instruction is taken at return
  task automatic enter_sleep(input logic arm, input logic [1:0] mode);
    @(posedge clk);
    sleep_arm          <= arm;
    sleep_depth_select <= mode;
    @(posedge clk);
    sleep_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
  endtask

  // one write to the core control register; taken at the edge where the task returns
  task automatic ctrl_write(input logic off, input logic unlock);
    @(posedge clk);
    ctrl_wr                  <= 1'b1;
    wr_brownout_sleep_off    <= off;
    wr_brownout_sleep_unlock <= unlock;
    @(posedge clk);
    ctrl_wr <= 1'b0;
  endtask
endmodule

// ===== verif/smc_sleep_ctrl_tb.sv
// self-checking testbench for the sleep mode controller
`timescale 1ns/1ns
module smc_sleep_ctrl_tb
  import smc_pkg::*;
;
  logic       clk;
  logic       rst_b;
  logic [3:0] fuses;
  logic       adc_en;
  logic       t0_async;
  logic [1:0] t0_mask;
  logic       gie;
  smc_wake_s  wake;
  logic       sleep_instr, sleep_arm, ctrl_wr, wr_off, wr_unlock;
  logic [1:0] depth;
  smc_clk_s   clk_en;
  logic       adc_start, brownout_enable, brownout_sleep_off;
  logic       core_halt, sleeping, resume_irq, resume_reset;
  int         n_fail;
  int         checked;
  localparam int BOD_WAIT  = 8;               // short detector settle time for simulation
  localparam int WAKE_BASE = HALT_CYCLES + 1; // start-up edge plus the halt cycles
  smc_clk_s   exp_clk [4] = '{CLK_IDLE, CLK_ADC_NR, CLK_PDOWN, CLK_PSAVE};
  logic [13:0] bad    [4] = '{14'h0000, 14'h0080, 14'h0800, 14'h0020};
  logic [13:0] good   [4] = '{14'h2000, 14'h0008, 14'h0c00, 14'h0020};

  // ==========================================================
  // clock, design and core model
  always #4 clk = ~clk;

  smc_sleep_ctrl #(.BOD_WAKE_CYCLES_P(BOD_WAIT)) i_smc_sleep_ctrl (
    .clk(clk), .rst_b(rst_b), .sleep_instr(sleep_instr), .sleep_arm(sleep_arm),
    .sleep_depth_select(depth), .clock_source_fuses(fuses), .adc_enabled(adc_en),
    .timer0_async_select(t0_async), .timer0_irq_mask(t0_mask), .global_irq_enable(gie),
    .wake(wake), .ctrl_wr(ctrl_wr), .wr_brownout_sleep_off(wr_off),
    .wr_brownout_sleep_unlock(wr_unlock), .clk_en(clk_en), .adc_start(adc_start),
    .brownout_enable(brownout_enable), .brownout_sleep_off(brownout_sleep_off),
    .core_halt(core_halt), .sleeping(sleeping), .resume_irq(resume_irq),
    .resume_reset(resume_reset));

  smc_core_model i_smc_core_model (
    .clk(clk), .sleep_instr(sleep_instr), .sleep_arm(sleep_arm),
    .sleep_depth_select(depth), .ctrl_wr(ctrl_wr), .wr_brownout_sleep_off(wr_off),
    .wr_brownout_sleep_unlock(wr_unlock));

  // ==========================================================
  // compare, verdict
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  task automatic finish_test();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // raise a wake source, count cycles from the edge that takes it to the resume pulse
  task automatic wake_and_time(input logic [13:0] src, input int exp_n, input logic irq);
    int   n;
    int   halts;
    logic bod1;
    logic osc1;
    n     = 0;
    halts = 0;
    bod1  = 1'b0;
    osc1  = 1'b0;
    @(posedge clk);
    wake <= src;
    @(posedge clk);
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n == 1) begin
        bod1 = brownout_enable;
        osc1 = clk_en.main_osc;
      end
      if (core_halt === 1'b1) begin
        halts++;
        chk(clk_en === CLK_ALL_ON && sleeping === 1'b1, "clocks during halt");
      end
    end while (resume_irq !== 1'b1 && resume_reset !== 1'b1 && n < 2000);
    chk(n == exp_n, "wake-up time");
    chk(halts == HALT_CYCLES, "halt length");
    chk(resume_irq === irq && resume_reset === !irq, "resume kind");
    chk(bod1 === 1'b1, "detector back on at wake");
    chk(osc1 === 1'b1, "oscillator restarted at wake");
    if (n >= 2000) finish_test();
    @(posedge clk);
    wake <= '0;
    @(posedge clk);
    #1;
    chk(sleeping === 1'b0 && clk_en === CLK_ALL_ON, "running after wake");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0; rst_b = 1'b0; fuses = 4'h0; adc_en = 1'b0; t0_async = 1'b0;
    t0_mask = 2'h0; gie = 1'b0; wake = '0; n_fail = 0; checked = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(clk_en === CLK_ALL_ON && brownout_enable === 1'b1, "reset clocks");
    chk(sleeping === 1'b0, "reset state");
    // sleep instruction without arming does nothing
    i_smc_core_model.enter_sleep(1'b0, MODE_IDLE);
    repeat (2) @(posedge clk);
    #1;
    chk(sleeping === 1'b0 && clk_en === CLK_ALL_ON && adc_start === 1'b0, "unarmed");
    @(posedge clk);
    adc_en   <= 1'b1;
    t0_async <= 1'b1;
    t0_mask  <= 2'h1;
    // every depth: clocks, conversion start, accepted wake sources, and a refused one outside Idle
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      fuses <= (m == 3) ? 4'h4 : 4'h0;
      gie   <= 1'b0;
      i_smc_core_model.enter_sleep(1'b1, m[1:0]);
      // entry outputs stand from the edge that took the instruction
      #1;
      chk(clk_en === exp_clk[m] && sleeping === 1'b1, "mode clocks");
      chk(adc_start === (m < 2), "conversion start");
      chk(brownout_enable === 1'b1, "detector kept on");
      if (bad[m] != 14'h0) begin
        @(posedge clk);
        wake <= bad[m];
        repeat (10) @(posedge clk);
        #1;
        chk(sleeping === 1'b1 && clk_en === exp_clk[m], "refused wake");
        @(posedge clk);
        wake <= '0;
        gie  <= 1'b1;
      end
      // level held until the resume, long enough to be seen
      wake_and_time(good[m], WAKE_BASE + ((m == 3) ? int'(STARTUP_CNT_1)
                    : (m == 2) ? int'(STARTUP_CNT_0) : 0), 1'b1);
    end
    // reset during power-down, with the shortest start-up again
    @(posedge clk);
    fuses <= 4'h0;
    i_smc_core_model.enter_sleep(1'b1, MODE_PDOWN);
    wake_and_time(14'h0001, WAKE_BASE + int'(STARTUP_CNT_0), 1'b0);
    // set write without the unlock write is ignored
    i_smc_core_model.ctrl_write(1'b1, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk(brownout_sleep_off === 1'b0, "locked sleep-off");
    // timed sequence, then sleep while the bit is effective
    i_smc_core_model.ctrl_write(1'b1, 1'b1);
    i_smc_core_model.ctrl_write(1'b1, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk(brownout_sleep_off === 1'b1, "sleep-off set");
    i_smc_core_model.enter_sleep(1'b1, MODE_PDOWN);
    @(posedge clk);
    #1;
    chk(brownout_enable === 1'b0 && sleeping === 1'b1, "detector off in sleep");
    repeat (3) @(posedge clk);
    #1;
    chk(brownout_sleep_off === 1'b0, "sleep-off cleared");
    wake_and_time(14'h0040, WAKE_BASE + int'(STARTUP_CNT_0) + BOD_WAIT,
                  1'b1);
    finish_test();
  end
endmodule
